/* File: core/gpio_sf_regs.svh */
// Register offsets, reset values and timing figures of the pin block
`ifndef GPIO_SF_REGS_SVH
`define GPIO_SF_REGS_SVH

`define ADDR_PIN_DIRECTION 8'h00
`define ADDR_PIN_VALUE 8'h01
`define ADDR_CHAINED_SELECT_ENABLE 8'h02
`define RST_PIN_DIRECTION 8'h00
`define RST_PIN_VALUE 8'h00
`define RST_CHAINED_SELECT_ENABLE 8'h00
`define RDATA_UNMAPPED 8'h00

`define PIN_COUNT 7
`define PIN_MUX0 0
`define PIN_MUX1 1
`define PIN_BUSY 2
`define PIN_FAULT 3
`define PIN_CLOCK 4
`define SELF_SLOT 3'h7

`define SYS_CLK_HZ 50000000
`define MASTER_HZ 1000000
`define CHOP_HZ 125000
`define CP_HZ 16000000
`define MASTER_DIV (`SYS_CLK_HZ / `MASTER_HZ)
`define CHOP_HALF_TICKS (`MASTER_HZ / `CHOP_HZ / 2)
`define CP_STEP (2 * `CP_HZ / `MASTER_HZ)
`define CP_MOD (`SYS_CLK_HZ / `MASTER_HZ)

`define CAL_FULL_MS 85
`define CAL_QUICK_MS 8
`define CAL_PERIOD_UNIT_MS 1000
`define CAL_FULL_TICKS (`CAL_FULL_MS * (`MASTER_HZ / 1000))
`define CAL_QUICK_TICKS (`CAL_QUICK_MS * (`MASTER_HZ / 1000))
`define CAL_PERIOD_UNIT_TICKS (`CAL_PERIOD_UNIT_MS * (`MASTER_HZ / 1000))
`define CAL_AMP_COUNT 4

`endif

/* File: core/gpio_sf_pkg.sv */
// Types shared by the pin block and its helpers
package gpio_sf_pkg;

   typedef struct packed {
      logic outside_mux_field_en;
      logic cal_busy_out;
      logic fault_int_out;
      logic int_clk_out;
      logic clock_input_enable;
   } special_function_config_t;

   typedef struct packed {
      logic clk_out_sel;
      logic clock_align_edge;
      logic [4:0] clk_div;
   } sync_cfg_t;

   typedef struct packed {
      logic cal_sel;
      logic [1:0] cal_rate;
   } cal_cfg_t;

   typedef struct packed {
      logic input_switch_a_first;
      logic input_switch_a_second;
      logic input_switch_b_first;
      logic input_switch_b_second;
      logic test_switch_first;
      logic test_switch_second;
   } switch_set_t;

   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_FULL = 2'b01,
      CAL_QUICK = 2'b10
   } cal_state_t;

endpackage

/* File: core/cal_sequencer.sv */
// Ripple calibration sequencer timed in master clock ticks
`timescale 1ns/1ns
`default_nettype none
`include "gpio_sf_regs.svh"
module cal_sequencer
   import gpio_sf_pkg::*;
#(
   parameter logic [23:0] FULL_TICKS = 24'(`CAL_FULL_TICKS),
   parameter logic [23:0] QUICK_TICKS = 24'(`CAL_QUICK_TICKS),
   parameter logic [23:0] PERIOD_TICKS = 24'(`CAL_PERIOD_UNIT_TICKS)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic tick,
   input wire logic start_full,
   input wire logic trigger,
   input wire cal_cfg_t cfg,
   output logic busy_r,
   output logic [1:0] amp_r,
   output logic all_r
);
   localparam logic [23:0] SLOT_TICKS = FULL_TICKS / 24'(`CAL_AMP_COUNT);
   localparam logic [1:0] LAST_AMP = 2'(`CAL_AMP_COUNT - 1);

   cal_state_t state_r, state_nxt;
   logic [23:0] cnt_r, cnt_nxt;
   logic [25:0] per_r, per_nxt;
   logic full_pend_r, full_pend_nxt;
   logic sel_pend_r, sel_pend_nxt;
   logic busy_nxt, all_nxt;
   logic [1:0] amp_nxt;
   logic [25:0] period;

   always_comb begin
      period = 26'(PERIOD_TICKS) * 26'(cfg.cal_rate);
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      amp_nxt = amp_r;
      per_nxt = per_r;
      full_pend_nxt = full_pend_r | start_full;
      sel_pend_nxt = sel_pend_r | trigger;
      case (state_r)
         CAL_IDLE: begin
            cnt_nxt = 24'h0;
            amp_nxt = 2'h0;
            if (full_pend_r) begin
               state_nxt = CAL_FULL;
               full_pend_nxt = start_full;
               sel_pend_nxt = sel_pend_r & ~cfg.cal_sel | trigger;
            end else if (sel_pend_r) begin
               state_nxt = cfg.cal_sel ? CAL_FULL : CAL_QUICK;
               sel_pend_nxt = trigger;
            end
         end
         CAL_FULL: begin
            if (tick) begin
               if (cnt_r + 24'h1 >= SLOT_TICKS) begin
                  cnt_nxt = 24'h0;
                  // One amplifier after another
                  if (amp_r == LAST_AMP) begin
                     state_nxt = CAL_IDLE;
                  end else begin
                     amp_nxt = amp_r + 2'h1;
                  end
               end else begin
                  cnt_nxt = cnt_r + 24'h1;
               end
            end
         end
         CAL_QUICK: begin
            if (tick) begin
               if (cnt_r + 24'h1 >= QUICK_TICKS) begin
                  state_nxt = CAL_IDLE;
               end else begin
                  cnt_nxt = cnt_r + 24'h1;
               end
            end
         end
         default: state_nxt = CAL_IDLE;
      endcase
      // Periodic request, after the state logic so it is never dropped
      if (cfg.cal_rate == 2'h0) begin
         per_nxt = 26'h0;
      end else if (tick) begin
         if (per_r + 26'h1 >= period) begin
            per_nxt = 26'h0;
            sel_pend_nxt = 1'b1;
         end else begin
            per_nxt = per_r + 26'h1;
         end
      end
      busy_nxt = state_nxt != CAL_IDLE;
      all_nxt = state_nxt == CAL_QUICK;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= CAL_IDLE;
         cnt_r <= 24'h0;
         per_r <= 26'h0;
         full_pend_r <= 1'b1;
         sel_pend_r <= 1'b0;
         busy_r <= 1'b0;
         amp_r <= 2'h0;
         all_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         per_r <= per_nxt;
         full_pend_r <= full_pend_nxt;
         sel_pend_r <= sel_pend_nxt;
         busy_r <= busy_nxt;
         amp_r <= amp_nxt;
         all_r <= all_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: core/chained_select.sv */
// Rotation of the host select over enabled pins and the device itself
`timescale 1ns/1ns
`default_nettype none
`include "gpio_sf_regs.svh"
module chained_select (
   input wire logic clk,
   input wire logic srst,
   input wire logic cs_n,
   input wire logic [6:0] en,
   output logic [6:0] pin_cs_n_r,
   output logic self_sel_r,
   output logic [2:0] ptr_r
);
   logic [2:0] ptr_nxt;
   logic [6:0] en_r;
   logic cs_prev_r;
   logic [6:0] pin_cs_n_nxt;
   logic self_sel_nxt;

   function automatic logic [2:0] next_slot(input logic [6:0] mask, input logic [3:0] from);
      logic [2:0] slot;
      slot = `SELF_SLOT;
      for (int i = `PIN_COUNT - 1; i >= 0; i--) begin
         if (mask[i] && 4'(i) >= from) begin
            slot = 3'(i);
         end
      end
      return slot;
   endfunction

   always_comb begin
      ptr_nxt = ptr_r;
      if (en != en_r) begin
         ptr_nxt = next_slot(en, 4'h0);
      end else if (!cs_prev_r && cs_n) begin
         // Last slot of the round is the device itself
         if (ptr_r == `SELF_SLOT) begin
            ptr_nxt = next_slot(en, 4'h0);
         end else begin
            ptr_nxt = next_slot(en, 4'(ptr_r) + 4'h1);
         end
      end
      for (int i = 0; i < `PIN_COUNT; i++) begin
         pin_cs_n_nxt[i] = !(ptr_r == 3'(i) && !cs_n);
      end
      self_sel_nxt = ptr_r == `SELF_SLOT && !cs_n;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ptr_r <= `SELF_SLOT;
         en_r <= 7'h00;
         cs_prev_r <= 1'b1;
         pin_cs_n_r <= 7'h7F;
         self_sel_r <= 1'b0;
      end else begin
         ptr_r <= ptr_nxt;
         en_r <= en;
         cs_prev_r <= cs_n;
         pin_cs_n_r <= pin_cs_n_nxt;
         self_sel_r <= self_sel_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: core/gpio_special_functions_scs.sv */
// General pins with special functions, clocking, calibration and chained select
// Notes on behaviour
// - Full calibration runs after power-on, supply undervoltage and soft reset.
// - During calibration outside switches open, test switches close, then restore.
// - Full calibration steps amplifiers one at a time, about 85 ms.
// - Quick calibration treats all amplifiers together, about 8 ms.
// - One select bit picks full or quick for scheduled and triggered runs.
// - Nonzero rate field repeats calibration periodically; zero means none.
// - Trigger bit starts one calibration of the selected type.
// - Direction bit per pin, one means output.
// - Value bit drives output pins; reads return input pin levels and the stored value of output pins.
// - Mux mode drives pins 0 and 1 from the mux field.
// - Busy mode drives pin 2 high while calibrating.
// - Fault mode drives pin 3 with the OR of all error bits and the undervoltage flag.
// - Pin 4 outputs chopping clock or master clock by select bit.
// - Pin 4 input clock, 1 to 31 MHz, divided to 1 MHz master.
// - Edge select: one syncs on rising edge, zero on falling.
// - Chopping and charge pump clocks derive from the master clock.
// - Chained select refused on pins holding a special function.
// - Host select pulses rotate over enabled pins ascending, then the device.
// - Serial data output released whenever the device is not addressed.
// - Undervoltage flag raised when either high supply falls below 8 V.
`timescale 1ns/1ns
`default_nettype none
`include "gpio_sf_regs.svh"
module gpio_special_functions_scs
   import gpio_sf_pkg::*;
#(
   parameter logic [23:0] CAL_FULL_TICKS = 24'(`CAL_FULL_TICKS),
   parameter logic [23:0] CAL_QUICK_TICKS = 24'(`CAL_QUICK_TICKS),
   parameter logic [23:0] CAL_PERIOD_TICKS = 24'(`CAL_PERIOD_UNIT_TICKS)
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata_r,
   input wire special_function_config_t special_function_config,
   input wire sync_cfg_t sync_cfg,
   input wire cal_cfg_t cal_cfg,
   input wire logic calibration_trigger,
   input wire logic soft_reset,
   input wire logic [1:0] outside_mux_field,
   input wire logic [15:0] error_bits,
   input wire logic vddh_below_8v,
   input wire logic vssh_below_8v,
   input wire switch_set_t switch_request,
   output switch_set_t switch_r,
   input wire logic [6:0] general_pin_i,
   output logic [6:0] general_pin_o_r,
   output logic [6:0] general_pin_oe_r,
   input wire logic host_cs_n,
   input wire logic sdo_i,
   output logic sdo_o_r,
   output logic sdo_oe_r,
   output logic self_selected_r,
   output logic hv_supply_undervoltage_r,
   output logic cal_busy_r,
   output logic [1:0] cal_amp_r,
   output logic cal_all_r,
   output logic master_tick_r,
   output logic chop_clk_r,
   output logic cp_clk_r
);
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [7:0] pin_direction_r, pin_direction_nxt;
   logic [7:0] pin_value_r, pin_value_nxt;
   logic [7:0] chained_select_enable_r, chained_select_enable_nxt;
   logic [7:0] reg_rdata_nxt;
   logic [7:0] sf_pins;
   logic [7:0] pin_read;

   // Pins already held by a special function
   always_comb begin
      sf_pins = 8'h00;
      sf_pins[`PIN_MUX0] = special_function_config.outside_mux_field_en;
      sf_pins[`PIN_MUX1] = special_function_config.outside_mux_field_en;
      sf_pins[`PIN_BUSY] = special_function_config.cal_busy_out;
      sf_pins[`PIN_FAULT] = special_function_config.fault_int_out;
      sf_pins[`PIN_CLOCK] = special_function_config.int_clk_out | special_function_config.clock_input_enable;
   end

   always_comb begin
      pin_direction_nxt = pin_direction_r;
      pin_value_nxt = pin_value_r;
      chained_select_enable_nxt = chained_select_enable_r;
      if (reg_wr) begin
         if (reg_addr == `ADDR_PIN_DIRECTION) begin
            pin_direction_nxt = {1'b0, reg_wdata[6:0]};
         end else if (reg_addr == `ADDR_PIN_VALUE) begin
            pin_value_nxt = {1'b0, reg_wdata[6:0]};
         end else if (reg_addr == `ADDR_CHAINED_SELECT_ENABLE) begin
            chained_select_enable_nxt = {1'b0, reg_wdata[6:0] & ~sf_pins[6:0]};
         end
      end
      // Input pins read their level, output pins their stored value
      pin_read = {1'b0, (pin_value_r[6:0] & pin_direction_r[6:0])
                        | (general_pin_i & ~pin_direction_r[6:0])};
      if (reg_addr == `ADDR_PIN_DIRECTION) begin
         reg_rdata_nxt = pin_direction_r;
      end else if (reg_addr == `ADDR_PIN_VALUE) begin
         reg_rdata_nxt = pin_read;
      end else if (reg_addr == `ADDR_CHAINED_SELECT_ENABLE) begin
         reg_rdata_nxt = chained_select_enable_r;
      end else begin
         reg_rdata_nxt = `RDATA_UNMAPPED;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         pin_direction_r <= `RST_PIN_DIRECTION;
         pin_value_r <= `RST_PIN_VALUE;
         chained_select_enable_r <= `RST_CHAINED_SELECT_ENABLE;
         reg_rdata_r <= `RDATA_UNMAPPED;
      end else begin
         pin_direction_r <= pin_direction_nxt;
         pin_value_r <= pin_value_nxt;
         chained_select_enable_r <= chained_select_enable_nxt;
         reg_rdata_r <= reg_rdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // Master clock, internal or from pin 4
   // ------------------------------------------------------------
   logic [5:0] int_div_r, int_div_nxt;
   logic int_lvl_r, int_lvl_nxt;
   logic ext_prev_r, ext_prev_nxt;
   logic [4:0] ext_cnt_r, ext_cnt_nxt;
   logic master_tick_nxt;
   logic use_ext;
   logic ext_edge;
   logic int_tick;
   logic [4:0] ext_div;

   always_comb begin
      use_ext = special_function_config.clock_input_enable && !pin_direction_r[`PIN_CLOCK];
      ext_div = (sync_cfg.clk_div == 5'h00) ? 5'h01 : sync_cfg.clk_div;
      ext_prev_nxt = general_pin_i[`PIN_CLOCK];
      // Chosen edge of the outside clock
      if (sync_cfg.clock_align_edge) begin
         ext_edge = !ext_prev_r && general_pin_i[`PIN_CLOCK];
      end else begin
         ext_edge = ext_prev_r && !general_pin_i[`PIN_CLOCK];
      end
      int_tick = int_div_r == 6'(`MASTER_DIV - 1);
      int_div_nxt = int_tick ? 6'h00 : int_div_r + 6'h01;
      int_lvl_nxt = int_lvl_r;
      if (int_div_r == 6'(`MASTER_DIV / 2 - 1) || int_tick) begin
         int_lvl_nxt = !int_lvl_r;
      end
      ext_cnt_nxt = ext_cnt_r;
      master_tick_nxt = 1'b0;
      if (use_ext) begin
         if (ext_edge) begin
            if (ext_cnt_r + 5'h01 >= ext_div) begin
               ext_cnt_nxt = 5'h00;
               master_tick_nxt = 1'b1;
            end else begin
               ext_cnt_nxt = ext_cnt_r + 5'h01;
            end
         end
      end else begin
         ext_cnt_nxt = 5'h00;
         master_tick_nxt = int_tick;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         int_div_r <= 6'h00;
         int_lvl_r <= 1'b0;
         ext_prev_r <= 1'b0;
         ext_cnt_r <= 5'h00;
         master_tick_r <= 1'b0;
      end else begin
         int_div_r <= int_div_nxt;
         int_lvl_r <= int_lvl_nxt;
         ext_prev_r <= ext_prev_nxt;
         ext_cnt_r <= ext_cnt_nxt;
         master_tick_r <= master_tick_nxt;
      end
   end

   // ------------------------------------------------------------
   // Chopping and charge pump clocks
   // ------------------------------------------------------------
   logic [1:0] chop_cnt_r, chop_cnt_nxt;
   logic chop_clk_nxt;
   logic [5:0] cp_acc_r, cp_acc_nxt;
   logic cp_clk_nxt;
   logic [6:0] cp_sum;

   always_comb begin
      chop_cnt_nxt = chop_cnt_r;
      chop_clk_nxt = chop_clk_r;
      if (master_tick_r) begin
         if (chop_cnt_r == 2'(`CHOP_HALF_TICKS - 1)) begin
            chop_cnt_nxt = 2'h0;
            chop_clk_nxt = !chop_clk_r;
         end else begin
            chop_cnt_nxt = chop_cnt_r + 2'h1;
         end
      end
      // Fractional step gives 31 toggles per master period, the accumulator clearing on each tick
      cp_sum = 7'(cp_acc_r) + 7'(`CP_STEP);
      cp_clk_nxt = cp_clk_r;
      if (master_tick_r) begin
         cp_acc_nxt = 6'h00;
      end else if (cp_sum >= 7'(`CP_MOD)) begin
         cp_acc_nxt = 6'(cp_sum - 7'(`CP_MOD));
         cp_clk_nxt = !cp_clk_r;
      end else begin
         cp_acc_nxt = 6'(cp_sum);
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         chop_cnt_r <= 2'h0;
         chop_clk_r <= 1'b0;
         cp_acc_r <= 6'h00;
         cp_clk_r <= 1'b0;
      end else begin
         chop_cnt_r <= chop_cnt_nxt;
         chop_clk_r <= chop_clk_nxt;
         cp_acc_r <= cp_acc_nxt;
         cp_clk_r <= cp_clk_nxt;
      end
   end

   // ------------------------------------------------------------
   // Undervoltage flag and calibration
   // ------------------------------------------------------------
   logic hv_nxt;
   logic hv_event;
   logic cal_start_full;

   always_comb begin
      hv_nxt = vddh_below_8v | vssh_below_8v;
      hv_event = hv_nxt && !hv_supply_undervoltage_r;
      cal_start_full = hv_event | soft_reset;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         hv_supply_undervoltage_r <= 1'b0;
      end else begin
         hv_supply_undervoltage_r <= hv_nxt;
      end
   end

   cal_sequencer #(
      .FULL_TICKS(CAL_FULL_TICKS),
      .QUICK_TICKS(CAL_QUICK_TICKS),
      .PERIOD_TICKS(CAL_PERIOD_TICKS)
   ) u_cal (
      .clk(clk),
      .srst(srst),
      .tick(master_tick_r),
      .start_full(cal_start_full),
      .trigger(calibration_trigger),
      .cfg(cal_cfg),
      .busy_r(cal_busy_r),
      .amp_r(cal_amp_r),
      .all_r(cal_all_r)
   );

   // Switch override while calibrating
   switch_set_t switch_nxt;

   always_comb begin
      switch_nxt = switch_request;
      if (cal_busy_r) begin
         switch_nxt.input_switch_a_first = 1'b0;
         switch_nxt.input_switch_a_second = 1'b0;
         switch_nxt.input_switch_b_first = 1'b0;
         switch_nxt.input_switch_b_second = 1'b0;
         switch_nxt.test_switch_first = 1'b1;
         switch_nxt.test_switch_second = 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         switch_r <= '0;
      end else begin
         switch_r <= switch_nxt;
      end
   end

   // ------------------------------------------------------------
   // Chained select
   // ------------------------------------------------------------
   logic [6:0] scs_cs_n;
   logic scs_self;
   logic scs_active;

   chained_select u_scs (
      .clk(clk),
      .srst(srst),
      .cs_n(host_cs_n),
      .en(chained_select_enable_r[6:0] & pin_direction_r[6:0]),
      .pin_cs_n_r(scs_cs_n),
      .self_sel_r(scs_self),
      .ptr_r()
   );

   // ------------------------------------------------------------
   // Pin drive and serial output
   // ------------------------------------------------------------
   logic [6:0] pin_o_nxt;
   logic [6:0] pin_oe_nxt;
   logic self_nxt;

   always_comb begin
      scs_active = |chained_select_enable_r[6:0];
      pin_oe_nxt = pin_direction_r[6:0];
      pin_o_nxt = pin_value_r[6:0];
      for (int i = 0; i < `PIN_COUNT; i++) begin
         if (chained_select_enable_r[i]) begin
            pin_o_nxt[i] = scs_cs_n[i];
         end
      end
      if (special_function_config.outside_mux_field_en) begin
         pin_o_nxt[`PIN_MUX0] = outside_mux_field[0];
         pin_o_nxt[`PIN_MUX1] = outside_mux_field[1];
      end
      if (special_function_config.cal_busy_out) begin
         pin_o_nxt[`PIN_BUSY] = cal_busy_r;
      end
      if (special_function_config.fault_int_out) begin
         pin_o_nxt[`PIN_FAULT] = (|error_bits) | hv_supply_undervoltage_r;
      end
      if (special_function_config.int_clk_out && !special_function_config.clock_input_enable) begin
         pin_o_nxt[`PIN_CLOCK] = sync_cfg.clk_out_sel ? chop_clk_r : int_lvl_r;
      end
      pin_o_nxt = pin_o_nxt & pin_oe_nxt;
      self_nxt = scs_active ? scs_self : !host_cs_n;
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         general_pin_o_r <= 7'h00;
         general_pin_oe_r <= 7'h00;
         self_selected_r <= 1'b0;
         sdo_o_r <= 1'b0;
         sdo_oe_r <= 1'b0;
      end else begin
         general_pin_o_r <= pin_o_nxt;
         general_pin_oe_r <= pin_oe_nxt;
         self_selected_r <= self_nxt;
         sdo_o_r <= sdo_i;
         sdo_oe_r <= self_nxt;
      end
   end
endmodule
`default_nettype wire

/* File: tb/gpio_sf_properties.sv */
// Port assertions of the pin block
`timescale 1ns/1ns
`default_nettype none
module gpio_sf_checker
   import gpio_sf_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire special_function_config_t special_function_config,
   input wire logic [15:0] error_bits,
   input wire logic vddh_below_8v,
   input wire logic host_cs_n,
   input wire switch_set_t switch_r,
   input wire logic [6:0] general_pin_o_r,
   input wire logic [6:0] general_pin_oe_r,
   input wire logic sdo_oe_r,
   input wire logic hv_supply_undervoltage_r,
   input wire logic cal_busy_r,
   input wire logic master_tick_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   property p_boot;
      $fell(srst) |-> ##[1:3] cal_busy_r;
   endproperty
   a_boot: assert property (p_boot) else $error("no boot calibration");
   property p_sw;
      $rose(cal_busy_r) |-> ##[0:2] (switch_r.test_switch_first && !switch_r.input_switch_a_first);
   endproperty
   a_sw: assert property (p_sw) else $error("switches not forced");
   property p_len;
      $rose(cal_busy_r) |-> cal_busy_r [*8];
   endproperty
   a_len: assert property (p_len) else $error("calibration too short");
   property p_busy;
      $rose(cal_busy_r) && special_function_config.cal_busy_out && general_pin_oe_r[2] |-> ##[0:2] general_pin_o_r[2];
   endproperty
   a_busy: assert property (p_busy) else $error("busy pin low");
   property p_fault;
      (|error_bits) && special_function_config.fault_int_out && general_pin_oe_r[3] |-> ##[0:2] general_pin_o_r[3];
   endproperty
   a_fault: assert property (p_fault) else $error("fault pin low");
   property p_uv;
      vddh_below_8v |-> ##[1:3] hv_supply_undervoltage_r;
   endproperty
   a_uv: assert property (p_uv) else $error("undervoltage flag missing");
   property p_sdo;
      host_cs_n [*3] |-> !sdo_oe_r;
   endproperty
   a_sdo: assert property (p_sdo) else $error("data output driven idle");
   property p_tick;
      master_tick_r && !special_function_config.clock_input_enable |->
         ##50 (master_tick_r || special_function_config.clock_input_enable);
   endproperty
   a_tick: assert property (p_tick) else $error("master tick period");
   c_cal: cover property ($rose(cal_busy_r));
   c_self: cover property ($rose(sdo_oe_r));
   c_uv: cover property (hv_supply_undervoltage_r);
endmodule
bind gpio_special_functions_scs gpio_sf_checker gpio_sf_checker_i (.clk, .srst, .special_function_config,
   .error_bits, .vddh_below_8v, .host_cs_n, .switch_r, .general_pin_o_r, .general_pin_oe_r,
   .sdo_oe_r, .hv_supply_undervoltage_r, .cal_busy_r, .master_tick_r);
`default_nettype wire

/* File: tb/spi_host_model.sv */
// Host controller issuing one select frame per request
`timescale 1ns/1ns
`default_nettype none
module spi_host_model (
   input wire logic clk,
   input wire logic go,
   output logic host_cs_n
);
   int n = 0;
   initial host_cs_n = 1'b1;
   always @(posedge clk) begin
      if (go && n == 0) n <= 12;
      else if (n > 0) n <= n - 1;
      host_cs_n <= !((go && n == 0) || n > 3);
   end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the pin block
`timescale 1ns/1ns
`default_nettype none
module tb
   import gpio_sf_pkg::*;
();
   logic clk = 0, srst = 1, reg_wr = 0, calibration_trigger = 0, soft_reset = 0, go = 0;
   logic vddh_below_8v = 0, host_cs_n, sdo_oe_r, self_selected_r, hv_supply_undervoltage_r;
   logic cal_busy_r, master_tick_r, sdo_o_r, sdo_i = 0;
   logic [1:0] outside_mux_field = 2'h0;
   sync_cfg_t sync_cfg = 7'h00;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_r;
   logic [15:0] error_bits = 16'h0000;
   logic [6:0] general_pin_i = 7'h00, general_pin_o_r, general_pin_oe_r;
   special_function_config_t special_function_config = 5'h08;
   cal_cfg_t cal_cfg = 3'h0;
   int error_cnt = 0, check_count = 0;
   gpio_special_functions_scs #(.CAL_FULL_TICKS(24'h28), .CAL_QUICK_TICKS(24'h08),
      .CAL_PERIOD_TICKS(24'h64)) gpio_special_functions_scs_i (.clk, .srst, .reg_wr,
      .reg_addr, .reg_wdata, .reg_rdata_r, .special_function_config, .sync_cfg, .cal_cfg,
      .calibration_trigger, .soft_reset, .outside_mux_field, .error_bits,
      .vddh_below_8v, .vssh_below_8v(1'b0), .switch_request(6'h00), .switch_r(),
      .general_pin_i, .general_pin_o_r, .general_pin_oe_r, .host_cs_n, .sdo_i,
      .sdo_o_r, .sdo_oe_r, .self_selected_r, .hv_supply_undervoltage_r, .cal_busy_r,
      .cal_amp_r(), .cal_all_r(), .master_tick_r, .chop_clk_r(), .cp_clk_r());
   spi_host_model spi_host_model_i (.clk, .go, .host_cs_n);
   initial forever #10 clk = ~clk;
   // ----
   // Shared tasks
   // ----
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      check_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      repeat (2) @(posedge clk);
      chk("read", e, reg_rdata_r);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_cal();
      int n;
      int t;
      wr(8'h00, 8'h04);
      for (int k = 0; k < 4; k++) begin
         if (k > 0) begin
            @(posedge clk);
            cal_cfg.cal_sel <= (k == 2);
            soft_reset <= (k == 1);
            calibration_trigger <= (k > 1);
            @(posedge clk);
            soft_reset <= 1'b0;
            calibration_trigger <= 1'b0;
         end
         t = (k < 3) ? 2000 : 400;
         repeat (3) @(posedge clk);
         chk("busy pin", 8'h01, general_pin_o_r[2]);
         for (n = 3; cal_busy_r === 1'b1 && n < 3000; n++) @(posedge clk);
         chk("busy span", 8'h01, n > t - 60 && n < t + 60);
      end
      cal_cfg.cal_rate <= 2'h1;
      for (n = 0; cal_busy_r !== 1'b1 && n < 6000; n++) @(posedge clk);
      cal_cfg.cal_rate <= 2'h0;
      chk("cal period", 8'h01, n > 4900 && n < 5100);
      $display("calibration test done");
   endtask
   task automatic t_scs();
      logic [7:0] ex[3] = '{8'h12, 8'h11, 8'h1F};
      sdo_i <= 1'b1;
      wr(8'h00, 8'h07);
      wr(8'h02, 8'h07);
      rd(8'h02, 8'h03);
      for (int k = 0; k < 6; k++) begin
         @(posedge clk);
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (6) @(posedge clk);
         chk("chain", ex[k % 3],
         {sdo_o_r, self_selected_r, sdo_oe_r, general_pin_o_r[1:0]});
         repeat (8) @(posedge clk);
      end
      $display("chained select test done");
   endtask
   task automatic t_gpio();
      wr(8'h02, 8'h00);
      wr(8'h00, 8'h00);
      general_pin_i <= 7'h15;
      repeat (3) @(posedge clk);
      rd(8'h01, 8'h15);
      rd(8'h05, 8'h00);
      wr(8'h00, 8'h4B);
      wr(8'h01, 8'h40);
      special_function_config <= 5'h1C;
      outside_mux_field <= 2'h2;
      error_bits <= 16'h0100;
      vddh_below_8v <= 1'b1;
      repeat (4) @(posedge clk);
      chk("pin enable", 8'h4B, {1'b0, general_pin_oe_r});
      chk("mux pins", 8'h02, general_pin_o_r[1:0]);
      chk("pin level", 8'h03, {general_pin_o_r[6], general_pin_o_r[3]});
      chk("undervoltage", 8'h01, hv_supply_undervoltage_r);
      rd(8'h00, 8'h4B);
      $display("pin test done");
   endtask
   task automatic t_clk();
      int n = 0;
      special_function_config.clock_input_enable <= 1'b1;
      sync_cfg <= 7'h22;
      for (int i = 0; i < 96; i++) begin
         @(posedge clk);
         general_pin_i[4] <= i[1];
         if (i > 0) n += master_tick_r;
      end
      chk("clock ticks", 8'h0B, 8'(n));
      $display("clock input test done");
   endtask
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      t_cal();
      t_scs();
      t_gpio();
      t_clk();
      print_verdict();
   end
   initial begin
      #400000;
      error_cnt++;
      print_verdict();
   end
endmodule
`default_nettype wire
